// File: verilog/ptb_timebase.sv
// periodic timebase interrupt: control register, crystal divider, flags and requests
//
// What this block does
// R1 - divider advances on edges of the crystal clock, meant to be 32.768 kHz
// R2 - divider chain has fifteen stages with eight selectable taps
// R3 - divider held at zero while the module enable bit is clear
// R4 - divider starts counting once the module enable bit is set
// R5 - overflow at the selected tap sets the pending flag; software cannot write it
// R6 - interrupt request raised while pending flag and interrupt enable are set
// R7 - first event after enabling at half period, later events at full period
// R8 - rate codes 0..7 divide by 32768,8192,2048,128,64,32,16,8
// R9 - software changes the rate only while the module is disabled; the block takes a rate write at any time
// R10 - writing one to acknowledge clears the pending flag; zero does nothing
// R11 - acknowledge bit is write-only and reads as zero
// R12 - software must acknowledge each interrupt to withdraw the request
// R13 - reset clears the interrupt enable bit
// R14 - reset clears the module enable, leaving the counter at zero
// R15 - counting and flagging continue in wait mode; registers unreachable there
// R16 - in stop, counting continues only with oscillator kept running; events wake
// R17 - without oscillator in stop the block is idle; registers unreachable in stop
// R18 - interrupt request is a level until acknowledged or enable cleared
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps

`include "ptb_map.svh"

module ptb_timebase
    import ptb_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          reset_i,
    input  wire logic          ce_i,
    // register port
    input  wire ptb_bus_req_s  bus_req_i,
    output logic [7:0]         bus_rdata_o,
    // crystal clock pin, sampled here
    input  wire logic          crystal_clock_i,
    // power mode and configuration from the core, same clock
    input  wire logic          wait_mode_i,
    input  wire logic          stop_mode_i,
    input  wire logic          oscillator_run_in_stop_i,
    // requests to the core
    output logic               tick_irq_o,
    output logic               irq_o,
    output logic               wakeup_o
);

    localparam ptb_top_state_s STATE_RESET = '{
        ctrl:      ptb_ctrl_s'(`PTB_CTRL_RESET),
        pending:   1'b0,
        status:    `PTB_EVT_RESET,
        mask:      `PTB_EVT_RESET,
        xtal_prev: 1'b0,
        wake:      1'b0,
        rdata:     8'h00
    };

    ptb_top_state_s s_q;
    ptb_top_state_s s_d;

    logic                   xtal_sync;
    logic                   xtal_tick;
    logic                   div_evt;
    logic [`PTB_STAGES-1:0] div_count;
    logic [15:0]            count_word;
    ptb_power_e             power;
    logic                   bus_open;
    logic                   wr;
    logic                   rd;
    logic                   ack_write;
    logic [`PTB_EVT_W-1:0]  status_clear;
    logic [`PTB_EVT_W-1:0]  status_set;
    logic [7:0]             ctrl_view;
    logic [7:0]             rd_mux;

    // crystal edges; the divider itself runs at bus rate and steps on each rising crystal edge
    ptb_sync u_xtal_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .async_i (crystal_clock_i),
        .sync_o  (xtal_sync)
    );

    assign xtal_tick = xtal_sync && !s_q.xtal_prev;        // R1

    always_comb begin
        unique case ({stop_mode_i, wait_mode_i})
            2'b00:   power = PTB_RUN;
            2'b01:   power = PTB_WAIT;
            default: power = oscillator_run_in_stop_i ? PTB_STOP_LIVE : PTB_STOP_IDLE;
        endcase
    end

    // the core cannot reach the register in wait or stop; such strobes are dropped
    assign bus_open = (power == PTB_RUN);                   // R15 R17
    assign wr       = bus_req_i.we && bus_open;
    assign rd       = bus_req_i.re && bus_open;

    // an idle stop freezes the divider but keeps its count; enable still clears it
    ptb_divider u_divider (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .ce_i        (ce_i),
        .xtal_tick_i (xtal_tick),
        .run_i       (s_q.ctrl.mod_en),                    // R3 R4
        .hold_i      (power == PTB_STOP_IDLE),             // R15 R16 R17
        .rate_i      (s_q.ctrl.rate),                      // R8
        .evt_o       (div_evt),
        .count_o     (div_count)
    );

    assign count_word = {{(16-`PTB_STAGES){1'b0}}, div_count};

    assign ack_write = wr && (bus_req_i.addr == `PTB_CTRL_OFFSET)
                       && bus_req_i.wdata[`PTB_ACK_BIT];   // R10

    assign status_clear = (wr && (bus_req_i.addr == `PTB_STATUS_OFFSET))
                          ? bus_req_i.wdata[`PTB_EVT_W-1:0] : '0;

    always_comb begin
        status_set                    = '0;
        status_set[`PTB_EVT_TICK_BIT] = div_evt;
        status_set[`PTB_EVT_WAKE_BIT] = div_evt && (power == PTB_STOP_LIVE);   // R16
    end

    always_comb begin
        ctrl_view                                  = 8'h00;
        ctrl_view[`PTB_PEND_BIT]                   = s_q.pending;
        ctrl_view[`PTB_RATE_MSB:`PTB_RATE_LSB]     = s_q.ctrl.rate;
        ctrl_view[`PTB_ACK_BIT]                    = 1'b0;          // R11
        ctrl_view[`PTB_IRQEN_BIT]                  = s_q.ctrl.irq_en;
        ctrl_view[`PTB_MODEN_BIT]                  = s_q.ctrl.mod_en;
    end

    always_comb begin
        unique case (bus_req_i.addr)
            `PTB_CTRL_OFFSET:   rd_mux = ctrl_view;
            `PTB_STATUS_OFFSET: rd_mux = {{(8-`PTB_EVT_W){1'b0}}, s_q.status};
            `PTB_MASK_OFFSET:   rd_mux = {{(8-`PTB_EVT_W){1'b0}}, s_q.mask};
            `PTB_CNT_LO_OFFSET: rd_mux = count_word[7:0];
            `PTB_CNT_HI_OFFSET: rd_mux = count_word[15:8];
            default:            rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        s_d           = s_q;
        s_d.xtal_prev = xtal_sync;

        // control register; pending bit is not writable
        if (wr && (bus_req_i.addr == `PTB_CTRL_OFFSET)) begin
            // a rate change while enabled is taken at once and may skip or split a period
            s_d.ctrl.rate   = bus_req_i.wdata[`PTB_RATE_MSB:`PTB_RATE_LSB];   // R8 R9
            s_d.ctrl.irq_en = bus_req_i.wdata[`PTB_IRQEN_BIT];
            s_d.ctrl.mod_en = bus_req_i.wdata[`PTB_MODEN_BIT];                // R3 R4
        end

        // an event in the same cycle as its acknowledge survives
        s_d.pending = (s_q.pending && !ack_write) || div_evt;   // R5 R10 R12

        if (wr && (bus_req_i.addr == `PTB_MASK_OFFSET)) begin
            s_d.mask = bus_req_i.wdata[`PTB_EVT_W-1:0];
        end

        s_d.status = (s_q.status & ~status_clear) | status_set;

        s_d.wake  = status_set[`PTB_EVT_WAKE_BIT];               // R16

        // read data stand only in the cycle after the strobe
        s_d.rdata = rd ? rd_mux : 8'h00;                         // R11
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= STATE_RESET;                                  // R13 R14
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign bus_rdata_o = s_q.rdata;
    assign tick_irq_o  = s_q.pending && s_q.ctrl.irq_en;         // R6 R18
    assign irq_o       = |(s_q.status & s_q.mask);
    assign wakeup_o    = s_q.wake;                               // R16

endmodule : ptb_timebase

// File: verilog/ptb_map.svh
// offsets, field positions, reset values and timing counts of the periodic timebase
`ifndef PTB_MAP_SVH
`define PTB_MAP_SVH

// register offsets
`define PTB_CTRL_OFFSET      8'h1c
`define PTB_STATUS_OFFSET    8'h1d
`define PTB_MASK_OFFSET      8'h1e
`define PTB_CNT_LO_OFFSET    8'h1f
`define PTB_CNT_HI_OFFSET    8'h20

// timebase_control field positions
`define PTB_PEND_BIT         7
`define PTB_RATE_MSB         6
`define PTB_RATE_LSB         4
`define PTB_ACK_BIT          3
`define PTB_IRQEN_BIT        2
`define PTB_MODEN_BIT        1

// event status / mask field positions
`define PTB_EVT_TICK_BIT     0
`define PTB_EVT_WAKE_BIT     1
`define PTB_EVT_W            2

// reset values
`define PTB_CTRL_RESET       8'h00
`define PTB_EVT_RESET        2'h0

// timing: crystal rate, bus clock rate and divider depth
`define PTB_XTAL_HZ          32768
`define PTB_CLK_HZ           100000000
`define PTB_STAGES           15

// counter bit whose rising edge marks an event; period is twice its weight
`define PTB_TAP_DIV_32768    4'd14
`define PTB_TAP_DIV_8192     4'd12
`define PTB_TAP_DIV_2048     4'd10
`define PTB_TAP_DIV_128      4'd6
`define PTB_TAP_DIV_64       4'd5
`define PTB_TAP_DIV_32       4'd4
`define PTB_TAP_DIV_16       4'd3
`define PTB_TAP_DIV_8        4'd2

`endif

// File: verilog/ptb_pkg.sv
// types shared by the periodic timebase modules
`include "ptb_map.svh"

package ptb_pkg;

    typedef logic [2:0] ptb_rate_t;

    typedef enum logic [1:0] {
        PTB_RUN,
        PTB_WAIT,
        PTB_STOP_LIVE,
        PTB_STOP_IDLE
    } ptb_power_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } ptb_bus_req_s;

    typedef struct packed {
        ptb_rate_t rate;
        logic      irq_en;
        logic      mod_en;
    } ptb_ctrl_s;

    typedef struct packed {
        logic meta;
        logic stable;
    } ptb_sync_state_s;

    typedef struct packed {
        logic [`PTB_STAGES-1:0] cnt;
        logic                   evt;
    } ptb_div_state_s;

    typedef struct packed {
        ptb_ctrl_s             ctrl;
        logic                  pending;
        logic [`PTB_EVT_W-1:0] status;
        logic [`PTB_EVT_W-1:0] mask;
        logic                  xtal_prev;
        logic                  wake;
        logic [7:0]            rdata;
    } ptb_top_state_s;

    function automatic logic [3:0] ptb_tap_index(input ptb_rate_t rate);
        logic [3:0] tap;
        tap = `PTB_TAP_DIV_32768;
        unique case (rate)
            3'd0: tap = `PTB_TAP_DIV_32768;
            3'd1: tap = `PTB_TAP_DIV_8192;
            3'd2: tap = `PTB_TAP_DIV_2048;
            3'd3: tap = `PTB_TAP_DIV_128;
            3'd4: tap = `PTB_TAP_DIV_64;
            3'd5: tap = `PTB_TAP_DIV_32;
            3'd6: tap = `PTB_TAP_DIV_16;
            3'd7: tap = `PTB_TAP_DIV_8;
        endcase
        return tap;
    endfunction : ptb_tap_index

endpackage : ptb_pkg

// File: verilog/ptb_sync.sv
// two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps

module ptb_sync
    import ptb_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic ce_i,
    input  wire logic async_i,
    output logic      sync_o
);

    ptb_sync_state_s s_q;
    ptb_sync_state_s s_d;

    // the meta flop feeds only the stable flop
    always_comb begin
        s_d        = s_q;
        s_d.meta   = async_i;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign sync_o = s_q.stable;

endmodule : ptb_sync

// File: verilog/ptb_divider.sv
// fifteen-stage crystal divider with selectable event tap
`timescale 1ns/1ps

`include "ptb_map.svh"

module ptb_divider
    import ptb_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   reset_i,
    input  wire logic                   ce_i,
    input  wire logic                   xtal_tick_i,
    input  wire logic                   run_i,
    input  wire logic                   hold_i,
    input  wire ptb_rate_t              rate_i,
    output logic                        evt_o,
    output logic [`PTB_STAGES-1:0]      count_o
);

    ptb_div_state_s s_q;
    ptb_div_state_s s_d;

    logic [3:0]             tap;
    logic [`PTB_STAGES-1:0] cnt_inc;

    assign tap     = ptb_tap_index(rate_i);
    assign cnt_inc = s_q.cnt + `PTB_STAGES'(1);

    always_comb begin
        s_d     = s_q;
        s_d.evt = 1'b0;
        if (!run_i) begin
            s_d.cnt = '0;                                   // R3
        end else if (xtal_tick_i && !hold_i) begin
            s_d.cnt = cnt_inc;                              // R1 R2 R4
            // rising edge of the tap bit: half a period after a restart, then every period
            s_d.evt = !s_q.cnt[tap] && cnt_inc[tap];        // R5 R7 R8
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign evt_o   = s_q.evt;
    assign count_o = s_q.cnt;

endmodule : ptb_divider

// File: testbench/ptb_timebase_assertions.sv
// concurrent checks on the periodic timebase ports
`timescale 1ns/1ps
module ptb_timebase_checker
    import ptb_pkg::*;
(
    input wire logic         clk_i,
    input wire logic         reset_i,
    input wire logic         ce_i,
    input wire ptb_bus_req_s bus_req_i,
    input wire logic [7:0]   bus_rdata_o,
    input wire logic         crystal_clock_i,
    input wire logic         wait_mode_i,
    input wire logic         stop_mode_i,
    input wire logic         oscillator_run_in_stop_i,
    input wire logic         tick_irq_o,
    input wire logic         irq_o,
    input wire logic         wakeup_o
);
    logic ok;
    logic rd_ok;
    logic wr_c;
    logic en_q;
    logic ien_q;
    assign ok    = ce_i && !wait_mode_i && !stop_mode_i;
    assign rd_ok = ok && bus_req_i.re;
    assign wr_c  = ok && bus_req_i.we && bus_req_i.addr == 8'h1c;
    // mirror of the enable bits as software last wrote them
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            en_q  <= 1'b0;
            ien_q <= 1'b0;
        end else if (wr_c) begin
            en_q  <= bus_req_i.wdata[1];
            ien_q <= bus_req_i.wdata[2];
        end
    end
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (reset_i);
    chk_rdata_idle: assert property (!$past(rd_ok) |-> bus_rdata_o == 8'h00)
        else $error("read data not zero outside a read answer");
    chk_ack_reads_zero: assert property ($past(rd_ok) && $past(bus_req_i.addr) == 8'h1c
        |-> bus_rdata_o[3] == 1'b0)
        else $error("acknowledge bit read back as one");
    // a crystal edge in flight could set the flag again in the same cycle
    chk_ack_clears: assert property ($stable(crystal_clock_i) [*4] ##1
        (wr_c && bus_req_i.wdata[3]) |=> !tick_irq_o)
        else $error("acknowledge did not withdraw the request");
    chk_ien_clears: assert property (wr_c && !bus_req_i.wdata[2] |=> !tick_irq_o)
        else $error("request stayed after interrupt enable cleared");
    chk_irq_needs_en: assert property (tick_irq_o |-> ien_q)
        else $error("request without interrupt enable");
    chk_fall_on_write: assert property ($fell(tick_irq_o) |-> $past(wr_c))
        else $error("request dropped without a control write");
    chk_held_no_event: assert property (!en_q [*8] |-> !$rose(tick_irq_o) || $past(wr_c))
        else $error("event while timebase disabled");
    chk_count_held: assert property (!en_q [*3] ##1 (rd_ok && bus_req_i.addr == 8'h1f)
        |=> bus_rdata_o == 8'h00)
        else $error("counter not zero while disabled");
    chk_stop_frozen: assert property ((stop_mode_i && !oscillator_run_in_stop_i) [*8]
        |-> !$rose(tick_irq_o) && !wakeup_o)
        else $error("activity in stop without oscillator");
    chk_wake_in_stop: assert property (wakeup_o
        |-> ($past(stop_mode_i) && $past(oscillator_run_in_stop_i)) ##1 !wakeup_o)
        else $error("wakeup outside live stop or longer than one cycle");
    cover property ($rose(tick_irq_o));
    cover property (wakeup_o);
    cover property ($rose(irq_o));
endmodule : ptb_timebase_checker

// File: testbench/ptb_xtal_model.sv
// crystal oscillator stand-in, held still while the oscillator is stopped
`timescale 1ns/1ps
module ptb_xtal_model #(
    parameter int HALF = 8
) (
    input  wire logic clk_i,
    input  wire logic run_i,
    output logic      crystal_clock_o
);
    int n = 0;
    initial crystal_clock_o = 1'b0;
    // much faster than a real crystal to keep runs short; each phase >= 2 clocks
    always @(posedge clk_i) begin
        if (run_i) begin
            n <= (n == HALF - 1) ? 0 : n + 1;
            if (n == HALF - 1)
                crystal_clock_o <= !crystal_clock_o;
        end
    end
endmodule : ptb_xtal_model

// File: testbench/tb_ptb_timebase.sv
// self-checking bench for the periodic timebase
`timescale 1ns/1ps
module tb_ptb_timebase
    import ptb_pkg::*;
;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    ptb_bus_req_s req = '0;
    logic [7:0]   rdata;
    logic         xtal;
    logic         wait_m = 1'b0;
    logic         stop_m = 1'b0;
    logic         osc = 1'b0;
    logic         tick;
    logic         irq;
    logic         wake;
    int           errors = 0;
    int           n_compared = 0;
    int           edges = 0;
    int           e0;
    int           k;

    ptb_xtal_model u_xtal (.clk_i(clk), .run_i(!(stop_m && !osc)), .crystal_clock_o(xtal));
    ptb_timebase u_dut (.clk_i(clk), .reset_i(rst), .ce_i(1'b1), .bus_req_i(req),
        .bus_rdata_o(rdata), .crystal_clock_i(xtal), .wait_mode_i(wait_m),
        .stop_mode_i(stop_m), .oscillator_run_in_stop_i(osc), .tick_irq_o(tick),
        .irq_o(irq), .wakeup_o(wake));

    initial forever #5 clk = !clk;
    always @(posedge xtal) edges++;

    task automatic report_and_stop();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_f(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask : chk_f
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) req.we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) req.re <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, exp});
    endtask : rd
    task automatic wait_for(input bit w);
        int i;
        for (i = 0; i < 40000 && (w ? wake : tick) !== 1'b1; i++)
            @(posedge clk) #1;
        if (i == 40000) begin
            errors++;
            report_and_stop();
        end
    endtask : wait_for
    // find a falling crystal edge, then let d clocks pass
    task automatic fall(input int d);
        int i;
        logic p;
        p = 1'b0;
        for (i = 0; i < 40 && !(p === 1'b1 && xtal === 1'b0); i++) begin
            p = xtal;
            @(posedge clk);
        end
        // a crystal that never falls means the far side is dead
        if (!(p === 1'b1 && xtal === 1'b0)) begin
            errors++;
            report_and_stop();
        end
        repeat (d) @(posedge clk);
    endtask : fall
    task automatic start(input logic [2:0] r);
        wr(8'h1c, 8'h08);
        fall(0);
        wr(8'h1c, {1'b0, r, 4'b1110});
        e0 = edges;
    endtask : start

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(8'h1c, 8'h00);
        rd(8'h1f, 8'h00);
        for (int r = 2; r < 8; r++) begin
            k = (r < 3) ? 15 - 2 * r : 10 - r;
            start(r[2:0]);
            wait_for(0);
            chk(16'(edges - e0), 16'(1 << (k - 1)));
            e0 = edges;
            rd(8'h1c, {1'b1, r[2:0], 4'b0110});
            wr(8'h1c, {1'b0, r[2:0], 4'b0110});
            #1 chk_f(tick, 1'b1);
            fall(4);
            wr(8'h1c, {1'b0, r[2:0], 4'b1110});
            @(posedge clk) #1 chk_f(tick, 1'b0);
            wait_for(0);
            chk(16'(edges - e0), 16'(1 << k));
        end
        wr(8'h1c, 8'h78);
        repeat (40) @(posedge clk);
        rd(8'h1f, 8'h00);
        rd(8'h20, 8'h00);
        wr(8'h1c, 8'h90);
        rd(8'h1c, 8'h10);
        wr(8'h1c, 8'h00);
        rd(8'h1c, 8'h00);
        rd(8'h40, 8'h00);
        wr(8'h1d, 8'h03);
        rd(8'h1d, 8'h00);
        wr(8'h1e, 8'h01);
        start(3'd7);
        wait_for(0);
        rd(8'h1d, 8'h01);
        chk_f(irq, 1'b1);
        wr(8'h1e, 8'h00);
        #1 chk_f(irq, 1'b0);
        wr(8'h1e, 8'h01);
        wr(8'h1d, 8'h01);
        #1 chk_f(irq, 1'b0);
        fall(4);
        wr(8'h1c, 8'h7e);
        wait_m <= 1'b1;
        wr(8'h1c, 8'h00);
        rd(8'h1c, 8'h00);
        wait_for(0);
        wait_m <= 1'b0;
        rd(8'h1c, 8'hf6);
        fall(4);
        wr(8'h1c, 8'h7e);
        osc <= 1'b1;
        stop_m <= 1'b1;
        wait_for(1);
        chk_f(wake, 1'b1);
        @(posedge clk) #1 chk_f(wake, 1'b0);
        stop_m <= 1'b0;
        rd(8'h1d, 8'h03);
        fall(4);
        wr(8'h1c, 8'h7e);
        osc <= 1'b0;
        stop_m <= 1'b1;
        repeat (300) @(posedge clk);
        #1 chk_f(tick, 1'b0);
        // second reset with a frozen nonzero count and live settings
        stop_m <= 1'b0;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(8'h1c, 8'h00);
        rd(8'h1f, 8'h00);
        report_and_stop();
    end
endmodule : tb_ptb_timebase

bind ptb_timebase ptb_timebase_checker u_chk (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .bus_req_i(bus_req_i), .bus_rdata_o(bus_rdata_o), .crystal_clock_i(crystal_clock_i),
    .wait_mode_i(wait_mode_i), .stop_mode_i(stop_mode_i),
    .oscillator_run_in_stop_i(oscillator_run_in_stop_i), .tick_irq_o(tick_irq_o),
    .irq_o(irq_o), .wakeup_o(wakeup_o));
